// File: sis_pkg.sv
package sis_pkg;

   // Shutter travel limit, in milliseconds, and the cycle count derived at 40 MHz.
   localparam int unsigned TRAVEL_MAX_MS     = 500;
   localparam int unsigned CLK_HZ            = 40_000_000;
   localparam int unsigned TRAVEL_MAX_CYCLES = TRAVEL_MAX_MS * (CLK_HZ / 1000);
   localparam int unsigned TRAVEL_CNT_W      = 25;

   // Number of two-stage synchronisers on the pin inputs.
   localparam int unsigned SYNC_W = 6;

   // Bit positions of the synchronised pin inputs.
   localparam int unsigned PIN_SYS_ILK  = 0;
   localparam int unsigned PIN_SHT_ILK  = 1;
   localparam int unsigned PIN_SHT_CMD  = 2;
   localparam int unsigned PIN_AT_OPEN  = 3;
   localparam int unsigned PIN_AT_SHUT  = 4;
   localparam int unsigned PIN_OVERTEMP = 5;

   // Reset values of the latched faults.
   localparam logic SHT_FAULT_RST = 1'b0;
   localparam logic OT_FAULT_RST  = 1'b0;

   // Status outputs toward the host.
   typedef struct packed {
      logic shut_closed;
      logic shut_open;
      logic shut_fault;
      logic overtemp_fault;
   } sis_status_type;

   // Shutter supervision states.
   typedef enum logic [3:0] {
      SIS_IDLE   = 4'b0001,
      SIS_MOVING = 4'b0010,
      SIS_SETTLED = 4'b0100,
      SIS_FAULT  = 4'b1000
   } sis_state_type;

endpackage : sis_pkg

// File: sis_sync.sv
`timescale 1ns/10ps
module sis_sync (
   input  wire logic                       sys_clk_i,
   input  wire logic                       rst_b_i,
   input  wire logic [sis_pkg::SYNC_W-1:0] async_i,
   output logic      [sis_pkg::SYNC_W-1:0] sync_o
);

   logic [sis_pkg::SYNC_W-1:0] stage1;
   logic [sis_pkg::SYNC_W-1:0] stage2;

   // Two flip-flops per bit; only the second stage is visible outside.
   genvar g;
   generate
      for (g = 0; g < sis_pkg::SYNC_W; g++) begin : g_bit
         always_ff @(posedge sys_clk_i) begin
            if (!rst_b_i) begin
               stage1[g] <= 1'b0;
               stage2[g] <= 1'b0;
            end else begin
               stage1[g] <= async_i[g];
               stage2[g] <= stage1[g];
            end
         end
      end
   endgenerate

   assign sync_o = stage2;

endmodule : sis_sync

// File: sis_core.sv
`timescale 1ns/10ps
module sis_core (
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    sys_ilk_closed_i,
   input  wire logic                    sht_ilk_closed_i,
   input  wire logic                    sht_cmd_open_i,
   input  wire logic                    net_ctrl_en_i,
   input  wire logic                    sht_at_open_i,
   input  wire logic                    sht_at_closed_i,
   input  wire logic                    overtemp_i,
   input  wire logic                    mod_req_i,
   output logic                         mod_en_o,
   output logic                         sht_drive_en_o,
   output logic                         sht_drive_open_o,
   output logic                         sys_shutdown_o,
   output sis_pkg::sis_status_type      status_o
);

   logic [sis_pkg::SYNC_W-1:0]       pin_raw;
   logic [sis_pkg::SYNC_W-1:0]       pin;
   logic                             sys_ilk;
   logic                             sht_fitted;
   logic                             at_open;
   logic                             at_closed;
   logic                             overtemp;
   logic                             cmd_open;
   logic                             target_open;
   logic                             shut_fault;
   logic                             ot_fault;
   logic                             any_fault;
   logic                             sht_active;
   logic                             at_target;
   logic                             travel_expired;
   logic                             stuck_midway;
   logic                             raise_sht_fault;
   logic                             loop_closed;
   logic                             mod_allowed;
   logic                             take_cmd;
   logic                             cmd_differs;
   logic                             restart_travel;
   logic                             in_moving;
   logic                             in_settled;
   logic [sis_pkg::TRAVEL_CNT_W-1:0] travel_cnt;
   sis_pkg::sis_state_type           state;
   sis_pkg::sis_state_type           next_state;

   // Travel limit as a counter value; it fits the counter width with room to spare.
   localparam logic [sis_pkg::TRAVEL_CNT_W-1:0] TRAVEL_LIMIT =
      sis_pkg::TRAVEL_CNT_W'(sis_pkg::TRAVEL_MAX_CYCLES);

   // Gather the pins that come from outside this clock domain. The loops are relay
   // contacts, so the flops below guard against metastability only, not bounce.
   assign pin_raw[sis_pkg::PIN_SYS_ILK]  = sys_ilk_closed_i;
   assign pin_raw[sis_pkg::PIN_SHT_ILK]  = sht_ilk_closed_i;
   assign pin_raw[sis_pkg::PIN_SHT_CMD]  = sht_cmd_open_i;
   assign pin_raw[sis_pkg::PIN_AT_OPEN]  = sht_at_open_i;
   assign pin_raw[sis_pkg::PIN_AT_SHUT]  = sht_at_closed_i;
   assign pin_raw[sis_pkg::PIN_OVERTEMP] = overtemp_i;

   // Two flip-flops per pin; nothing here reads the first stage.
   sis_sync u_sync (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .async_i   (pin_raw),
      .sync_o    (pin)
   );

   // Synchronised pin levels. Every pin reaches the logic two edges after it
   // changes, so the sensors and the fitted flag stay in step with each other.
   assign sys_ilk    = pin[sis_pkg::PIN_SYS_ILK];
   assign sht_fitted = pin[sis_pkg::PIN_SHT_ILK];
   assign cmd_open   = pin[sis_pkg::PIN_SHT_CMD];
   assign at_open    = pin[sis_pkg::PIN_AT_OPEN];
   assign at_closed  = pin[sis_pkg::PIN_AT_SHUT];
   assign overtemp   = pin[sis_pkg::PIN_OVERTEMP];

   // Fault summary and shutter enable. Either latched fault removes the shutter
   // enable as well as the laser.
   assign any_fault  = shut_fault | ot_fault;
   assign sht_active = sht_fitted & ~any_fault;

   // Modulation needs the system loop closed and no latched fault; the
   // shutter interlock deliberately plays no part here, so a missing or
   // unfitted shutter never holds the laser off.
   assign loop_closed    = sys_ilk;
   assign mod_allowed    = loop_closed & ~any_fault;
   assign sys_shutdown_o = any_fault;
   assign mod_en_o       = mod_req_i & mod_allowed;

   // Shutter drive outputs follow the held target while the shutter is usable.
   // With the enable low both drive lines rest low, so a disabled shutter is never driven.
   assign sht_drive_en_o   = sht_active;
   assign sht_drive_open_o = sht_active & target_open;

   // State decode shared by the supervisor, the timer and the fault terms.
   assign in_moving  = (state == sis_pkg::SIS_MOVING);
   assign in_settled = (state == sis_pkg::SIS_SETTLED);

   // The host command is taken only while network control is off. A changed
   // command seen while settled starts a fresh travel toward the new target.
   assign take_cmd       = ~net_ctrl_en_i;
   assign cmd_differs    = cmd_open ^ target_open;
   assign restart_travel = in_settled & sht_active & take_cmd & cmd_differs;

   // Supervision terms for travel timing and a shutter parked midway. A
   // target needs exactly one sensor high, so a blade that shows both or
   // neither never counts as arrived.
   assign at_target      = target_open ? (at_open & ~at_closed) : (at_closed & ~at_open);
   assign travel_expired = (travel_cnt >= TRAVEL_LIMIT);
   assign stuck_midway   = in_settled & ~at_target;
   assign raise_sht_fault = sht_active & ((in_moving & travel_expired) | stuck_midway);

   // Target position: the host command is taken only without network control.
   // Network control freezes the target, so the shutter stays where it was put.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         target_open <= 1'b0;
      end else if (take_cmd) begin
         target_open <= cmd_open;
      end
   end

   // Next state of the shutter supervisor. Losing the enable sends every state
   // but fault back to idle; the fault state is left only through reset.
   always_comb begin
      next_state = state;
      unique case (state)
         sis_pkg::SIS_IDLE: begin
            // Becoming usable always starts a timed travel to the current target.
            if (sht_active) begin
               next_state = sis_pkg::SIS_MOVING;
            end
         end
         sis_pkg::SIS_MOVING: begin
            // A command change mid-travel retargets the same timed travel.
            if (!sht_active) begin
               next_state = sis_pkg::SIS_IDLE;
            end else if (travel_expired) begin
               next_state = sis_pkg::SIS_FAULT;
            end else if (at_target) begin
               next_state = sis_pkg::SIS_SETTLED;
            end
         end
         sis_pkg::SIS_SETTLED: begin
            // Any drift off the target once settled is a blade stuck midway.
            if (!sht_active) begin
               next_state = sis_pkg::SIS_IDLE;
            end else if (!at_target) begin
               next_state = sis_pkg::SIS_FAULT;
            end
         end
         sis_pkg::SIS_FAULT: begin
            // Only reset leaves this state.
            next_state = sis_pkg::SIS_FAULT;
         end
      endcase
   end

   // A new command while settled starts a fresh travel. The restart is taken on the
   // edge that loads the new target, so the old position looks stuck midway only when
   // the command is loaded on the edge that enters settled.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         state <= sis_pkg::SIS_IDLE;
      end else if (restart_travel) begin
         state <= sis_pkg::SIS_MOVING;
      end else begin
         state <= next_state;
      end
   end

   // Travel timer restarts whenever a new travel begins.
   // The count saturates at the limit, so a long fault never wraps it back.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || !in_moving) begin
         travel_cnt <= '0;
      end else if (!travel_expired) begin
         travel_cnt <= travel_cnt + 1'b1;
      end
   end

   // Latched faults; only reset clears them. The cause is ORed into the held
   // value, so a cause that comes and goes still leaves the fault standing
   // until the next reset.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         shut_fault <= sis_pkg::SHT_FAULT_RST;
         ot_fault   <= sis_pkg::OT_FAULT_RST;
      end else begin
         shut_fault <= shut_fault | raise_sht_fault;
         ot_fault   <= ot_fault | overtemp;
      end
   end

   // Registered status outputs. Status leaves flip-flops so the host sees clean
   // levels; the position bits carry the shutter enable, so any fault or a
   // missing shutter clears them.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) begin
         status_o <= '0;
      end else begin
         status_o.shut_closed    <= sht_active & at_closed & ~at_open;
         status_o.shut_open      <= sht_active & at_open & ~at_closed;
         status_o.shut_fault     <= shut_fault;
         status_o.overtemp_fault <= ot_fault;
      end
   end

endmodule : sis_core

// File: sis_core_properties.sv
`timescale 1ns/10ps
module sis_core_properties (
   input  wire logic                    sys_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    sys_ilk_closed_i,
   input  wire logic                    sht_ilk_closed_i,
   input  wire logic                    net_ctrl_en_i,
   input  wire logic                    overtemp_i,
   input  wire logic                    mod_req_i,
   input  wire logic                    mod_en_o,
   input  wire logic                    sht_drive_en_o,
   input  wire logic                    sht_drive_open_o,
   input  wire logic                    sys_shutdown_o,
   input  wire sis_pkg::sis_status_type status_o
);
   // All checks run on the system clock and sleep through reset.
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   a_mod_needs_req: assert property (mod_en_o |-> mod_req_i)
      else $error("modulation enabled without a request");
   a_ilk_stops_mod: assert property (!sys_ilk_closed_i [*3] |-> !mod_en_o)
      else $error("modulation with the interlock loop open");
   a_ilk_no_shutter: assert property (!sht_ilk_closed_i [*3] |-> !sht_drive_en_o)
      else $error("shutter driven while not fitted");
   a_pos_exclusive: assert property (!(status_o.shut_open && status_o.shut_closed))
      else $error("shutter reported open and closed");
   a_closed_fitted: assert property (!sht_ilk_closed_i [*4] |-> !status_o.shut_closed)
      else $error("closed reported with no shutter fitted");
   a_fault_disables: assert property (
      sys_shutdown_o |-> (!sht_drive_en_o && !mod_en_o) ##1 !status_o.shut_closed)
      else $error("shutter, modulation or closed status active during a fault");
   a_ot_shutdown: assert property (overtemp_i [*3] |-> ##[0:2] sys_shutdown_o)
      else $error("over-temperature did not shut down");
   a_cmd_frozen: assert property (
      net_ctrl_en_i [*4] ##0 (sht_drive_en_o && $past(sht_drive_en_o))
      |-> $stable(sht_drive_open_o))
      else $error("shutter target moved under network control");
   a_sht_fault_stop: assert property (status_o.shut_fault |-> sys_shutdown_o)
      else $error("shutter fault without shutdown");
   a_ot_sticky: assert property (status_o.overtemp_fault |=> status_o.overtemp_fault)
      else $error("over-temperature fault cleared without reset");
   // Main scenarios reached by the bench.
   c_closed: cover property (status_o.shut_closed);
   c_open: cover property (status_o.shut_open);
   c_sht_fault: cover property (status_o.shut_fault);
endmodule : sis_core_properties

bind sis_core sis_core_properties u_sis_core_properties (
   .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sys_ilk_closed_i(sys_ilk_closed_i),
   .sht_ilk_closed_i(sht_ilk_closed_i), .net_ctrl_en_i(net_ctrl_en_i),
   .overtemp_i(overtemp_i), .mod_req_i(mod_req_i), .mod_en_o(mod_en_o),
   .sht_drive_en_o(sht_drive_en_o), .sht_drive_open_o(sht_drive_open_o),
   .sys_shutdown_o(sys_shutdown_o), .status_o(status_o));

// File: sis_shutter_model.sv
`timescale 1ns/10ps
module sis_shutter_model #(
   parameter int unsigned DELAY = 20
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_b_i,
   input  wire logic fitted_i,
   input  wire logic stuck_i,
   input  wire logic drive_en_i,
   input  wire logic drive_open_i,
   output logic      at_open_o,
   output logic      at_closed_o
);
   logic [7:0] cnt;
   // Travels DELAY cycles with both sensors low; a stuck blade sits midway.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i || !fitted_i || stuck_i) begin
         at_open_o <= 1'b0;
         at_closed_o <= 1'b0;
         cnt <= 8'h00;
      end else if (drive_en_i && (drive_open_i ? !at_open_o : !at_closed_o)) begin
         at_open_o <= (cnt == DELAY[7:0]) && drive_open_i;
         at_closed_o <= (cnt == DELAY[7:0]) && !drive_open_i;
         cnt <= (cnt == DELAY[7:0]) ? 8'h00 : cnt + 8'h01;
      end
   end
endmodule : sis_shutter_model

// File: tb.sv
`timescale 1ns/10ps
module tb;
   logic sys_clk_i = 1'b0, rst_b_i = 1'b0, sys_ilk = 1'b0, sht_ilk = 1'b0, cmd_open = 1'b0;
   logic net_ctrl = 1'b0, overtemp = 1'b0, mod_req = 1'b0, stuck = 1'b0;
   logic at_open, at_closed, mod_en, drv_en, drv_open, shutdown;
   logic mod_en_w, drv_en_w, drv_open_w, shutdown_w;
   sis_pkg::sis_status_type status, status_w;
   int fails = 0, check_count = 0, cycles = 0;
   sis_core u_sis_core (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sys_ilk_closed_i(sys_ilk),
      .sht_ilk_closed_i(sht_ilk), .sht_cmd_open_i(cmd_open), .net_ctrl_en_i(net_ctrl),
      .sht_at_open_i(at_open), .sht_at_closed_i(at_closed), .overtemp_i(overtemp),
      .mod_req_i(mod_req), .mod_en_o(mod_en_w), .sht_drive_en_o(drv_en_w),
      .sht_drive_open_o(drv_open_w), .sys_shutdown_o(shutdown_w), .status_o(status_w));
   sis_shutter_model u_sis_shutter_model (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .fitted_i(sht_ilk), .stuck_i(stuck), .drive_en_i(drv_en_w), .drive_open_i(drv_open_w),
      .at_open_o(at_open), .at_closed_o(at_closed));
   // Clock and a cycle ceiling that cuts a hang short.
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   // Outputs are copied at the falling edge, so checks at the rising edge see settled values.
   always @(negedge sys_clk_i) begin
      mod_en   <= mod_en_w;
      drv_en   <= drv_en_w;
      drv_open <= drv_open_w;
      shutdown <= shutdown_w;
      status   <= status_w;
   end
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask : wait_cyc
   task automatic do_reset();
      rst_b_i <= 1'b0;
      wait_cyc(12);
      rst_b_i <= 1'b1;
      wait_cyc(1);
   endtask : do_reset
   // Modulation follows the system loop only, never the shutter loop.
   task automatic t_modulation();
      sys_ilk <= 1'b1;
      mod_req <= 1'b1;
      wait_cyc(5);
      chk("mod_en closed", {3'h0, mod_en}, 4'h1);
      chk("mod_en no shutter", {3'h0, mod_en & ~drv_en}, 4'h1);
      sys_ilk <= 1'b0;
      wait_cyc(5);
      chk("mod_en open", {3'h0, mod_en}, 4'h0);
      sys_ilk <= 1'b1;
   endtask : t_modulation
   // Command the shutter both ways, freeze it, then unfit it.
   task automatic t_shutter();
      sht_ilk <= 1'b1;
      wait_cyc(40);
      chk("status closed", status, 4'h8);
      cmd_open <= 1'b1;
      wait_cyc(40);
      chk("status open", status, 4'h4);
      chk("drive open", {2'h0, drv_en, drv_open}, 4'h3);
      net_ctrl <= 1'b1;
      cmd_open <= 1'b0;
      wait_cyc(40);
      chk("status frozen", status, 4'h4);
      chk("drive frozen", {2'h0, drv_en, drv_open}, 4'h3);
      net_ctrl <= 1'b0;
      wait_cyc(40);
      chk("status closed again", status, 4'h8);
      chk("drive closed", {2'h0, drv_en, drv_open}, 4'h2);
      sht_ilk <= 1'b0;
      wait_cyc(6);
      chk("unfitted drive", {3'h0, drv_en}, 4'h0);
      chk("unfitted status", status, 4'h0);
   endtask : t_shutter
   // A blade stuck midway latches a fault that outlives its cause.
   task automatic t_stuck();
      sht_ilk <= 1'b1;
      wait_cyc(40);
      stuck <= 1'b1;
      wait_cyc(8);
      chk("stuck status", status, 4'h2);
      chk("stuck shutdown", {shutdown, drv_en, mod_en, 1'b0}, 4'h8);
      stuck <= 1'b0;
      wait_cyc(40);
      chk("stuck held", status, 4'h2);
      do_reset();
      chk("after reset", status, 4'h0);
   endtask : t_stuck
   // A short over-temperature pulse latches a shutdown.
   task automatic t_overtemp();
      overtemp <= 1'b1;
      wait_cyc(5);
      overtemp <= 1'b0;
      wait_cyc(10);
      chk("overtemp status", {status[3:1], status.overtemp_fault}, 4'h1);
      chk("overtemp shutdown", {shutdown, mod_en, 2'h0}, 4'h8);
   endtask : t_overtemp
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   initial begin
      do_reset();
      chk("reset status", status, 4'h0);
      t_modulation();
      t_shutter();
      t_stuck();
      t_overtemp();
      tally_and_finish();
   end
endmodule : tb
